// [lorl_consts.svh]
// Offsets, field positions and timing counts for the latching relay block
`ifndef LORL_CONSTS_SVH
`define LORL_CONSTS_SVH

`define LORL_NUM_RELAYS 4
`define LORL_NUM_SLOTS 7
`define LORL_SEL_W 4
`define LORL_NUM_TRIGS 15
`define LORL_TIME_W 16
`define LORL_ADDR_W 7

// Per-relay window: relay r at byte address r*RELAY_STRIDE
`define LORL_RELAY_STRIDE 7'h10
`define LORL_OFS_SEL 2'h0
`define LORL_OFS_CFG 2'h1
`define LORL_OFS_HOLD 2'h2
`define LORL_OFS_OFFDLY 2'h3
`define LORL_ADDR_CTRL 7'h40
`define LORL_ADDR_ACK 7'h44
`define LORL_ADDR_STATUS 7'h48

// Relay configuration word fields
`define LORL_CFG_INV_LSB 0
`define LORL_CFG_COLLINV 7
`define LORL_CFG_CLOSED 8
`define LORL_CFG_LATCH 9
`define LORL_CFG_ACKSEL_LSB 10
`define LORL_CFG_W 14

// Global control and acknowledge fields
`define LORL_CTRL_REMOTE 0
`define LORL_ACK_GROUP 8
`define LORL_STAT_HEALTH 16
`define LORL_STAT_REMOTE 17

// Reset values
`define LORL_SEL_RST 28'h0000000
`define LORL_CFG_RST 14'h0000
`define LORL_TIME_RST 16'h0000

// Timebase: one tick per millisecond
`define LORL_CLK_KHZ 25000
`define LORL_TICK_US 1000
`define LORL_TICK_CYCLES ((`LORL_TICK_US * `LORL_CLK_KHZ) / 1000)

`endif

// [lorl_pkg.sv]
// Types shared by the latching relay block
`include "lorl_consts.svh"
package lorl_pkg;
    typedef logic [`LORL_SEL_W-1:0] lorl_sel_t;
    typedef logic [`LORL_TIME_W-1:0] lorl_time_t;
    typedef logic [`LORL_NUM_TRIGS-1:0] lorl_trig_t;
    typedef enum logic {LORL_IDLE, LORL_ANSWER} lorl_bus_t;
endpackage

// [lorl_relay_if.sv]
// Configuration and status carrier between top and one relay channel
`timescale 1ns/1ns
`default_nettype none
`include "lorl_consts.svh"
interface lorl_relay_if;
    logic [`LORL_NUM_SLOTS*`LORL_SEL_W-1:0] sel;
    logic [`LORL_NUM_SLOTS-1:0] inv;
    logic collInv;
    logic closedCircuit;
    logic latchEn;
    logic [`LORL_SEL_W-1:0] ackSel;
    logic [`LORL_TIME_W-1:0] holdTicks;
    logic [`LORL_TIME_W-1:0] offTicks;
    logic scadaAck;
    logic contact;
    logic latched;
    logic logicState;
    modport ctrl(output sel, inv, collInv, closedCircuit, latchEn, ackSel,
        holdTicks, offTicks, scadaAck, input contact, latched, logicState);
    modport chan(input sel, inv, collInv, closedCircuit, latchEn, ackSel,
        holdTicks, offTicks, scadaAck, output contact, latched, logicState);
endinterface
`default_nettype wire

// [lorl_relay_channel.sv]
// One configurable output relay: combine, latch, acknowledge, dwell
`timescale 1ns/1ns
`default_nettype none
`include "lorl_consts.svh"
module lorl_relay_channel
    import lorl_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic retainRst,
    input wire logic tick,
    input wire lorl_trig_t trigIn,
    input wire logic panelAck,
    input wire logic groupAck,
    lorl_relay_if.chan ch
);
    // Selector 0 means unassigned and always reads 0
    function automatic logic pick(input lorl_trig_t t, input lorl_sel_t s);
        pick = (s == '0) ? 1'b0 : t[s - 4'h1];
    endfunction

    logic anyAssigned, condOr, combState, ackReq, ackReady, desired;
    logic latchReg, latchNext, stateReg, stateNext, contactReg, contactNext;
    lorl_time_t offCnt, offNext, holdCnt, holdNext;

    always_comb begin
        anyAssigned = 1'b0;
        condOr = 1'b0;
        for (int i = 0; i < `LORL_NUM_SLOTS; i++) begin
            if (ch.sel[i*`LORL_SEL_W +: `LORL_SEL_W] != '0) begin
                anyAssigned = 1'b1;
                condOr = condOr | (pick(trigIn,
                    ch.sel[i*`LORL_SEL_W +: `LORL_SEL_W]) ^ ch.inv[i]);
            end
        end
        combState = anyAssigned & (condOr ^ ch.collInv);
        ackReq = panelAck | ch.scadaAck | groupAck
            | (ch.latchEn & pick(trigIn, ch.ackSel));
        ackReady = !combState && offCnt == '0;
        // Retention delay restarts while the combined trigger state is still high
        if (combState)
            offNext = ch.offTicks;
        else if (tick && offCnt != '0)
            offNext = offCnt - 16'h0001;
        else
            offNext = offCnt;
        if (!ch.latchEn || !anyAssigned)
            latchNext = 1'b0;
        else if (combState)
            latchNext = 1'b1;
        else if (ackReq && ackReady)
            latchNext = 1'b0;
        else
            latchNext = latchReg;
        desired = combState | (ch.latchEn & latchReg);
        if (holdCnt == '0 && desired != stateReg) begin
            stateNext = desired;
            holdNext = ch.holdTicks;
        end else begin
            stateNext = stateReg;
            holdNext = (tick && holdCnt != '0) ? holdCnt - 16'h0001 : holdCnt;
        end
        contactNext = stateNext ^ ch.closedCircuit;
    end

    // Latch sits in the retained domain so restarts do not lose it
    always_ff @(posedge sys_clk or posedge retainRst) begin
        if (retainRst) begin
            latchReg <= 1'b0;
        end else begin
            latchReg <= latchNext;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            offCnt <= `LORL_TIME_RST;
            holdCnt <= `LORL_TIME_RST;
            stateReg <= 1'b0;
            contactReg <= 1'b0;
        end else begin
            offCnt <= offNext;
            holdCnt <= holdNext;
            stateReg <= stateNext;
            contactReg <= contactNext;
        end
    end

    assign ch.contact = contactReg;
    assign ch.latched = latchReg;
    assign ch.logicState = stateReg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst || retainRst);

    a_unassigned_zero: assert property (!anyAssigned |-> !combState)
        else $error("state high with no trigger assigned");
    a_or_combine: assert property (anyAssigned && !ch.collInv && condOr
        |-> combState) else $error("OR of triggers not reflected");
    a_mode_drive: assert property (!$past(rst) |-> contactReg ==
        (stateReg ^ $past(ch.closedCircuit))) else $error("contact level wrong");
    a_follow_nonlatch: assert property (!ch.latchEn && holdCnt == '0
        |=> stateReg == $past(combState)) else $error("output not following");
    a_latch_keep: assert property (ch.latchEn && anyAssigned && latchReg
        && !ackReady |=> latchReg) else $error("latch lost early");
    a_ack_after_drop: assert property ($fell(latchReg) |->
        !$past(ch.latchEn) || !$past(anyAssigned)
        || ($past(offCnt) == '0 && !$past(combState)))
        else $error("latch cleared before retention ended");
    a_dwell_hold: assert property (holdCnt != '0 |=> $stable(stateReg))
        else $error("relay changed inside dwell");
    a_dwell_load: assert property ($changed(stateReg)
        |-> holdCnt == $past(ch.holdTicks)) else $error("dwell not loaded");
endmodule // lorl_relay_channel
`default_nettype wire

// [lorl_relay_top.sv]
// Latching output relay block with Avalon-MM registers and health contact
//
// Overview of operation
// - each relay ORs up to seven conditioned trigger signals
// - each slot has own inversion; unassigned slot always gives 0
// - collective inversion of result; stays 0 when nothing assigned
// - per-relay mode picks working-current or closed-circuit drive level
// - without latching the contact follows the combined trigger state
// - with latching the asserted state is stored until acknowledged
// - own acknowledge signal acts only when latching and triggers dropped
// - acknowledgment accepted only after triggers drop and delay expires
// - latch clears by ack, ack signal, unlatch or no assignment
// - latched states survive warm and cold restarts; here they survive rst only, retainRst clears them
// - after each change relay holds state for minimum dwell time
// - single relay acknowledged by panel clear key or own signal
// - group or supervisory ack of all relays needs remote enable
// - health contact dropped in boot; picks up when started, fault free
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "lorl_consts.svh"
module lorl_relay_top
    import lorl_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `LORL_TICK_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic retainRst,
    input wire logic [`LORL_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [`LORL_NUM_TRIGS-1:0] trigIn,
    input wire logic [`LORL_NUM_RELAYS-1:0] panelAck,
    input wire logic group_output_ack_source,
    input wire logic bootDone,
    input wire logic internalFault,
    output logic [`LORL_NUM_RELAYS-1:0] relayContact,
    output logic health_contact,
    output logic healthLed
);
    localparam int NR = `LORL_NUM_RELAYS;
    localparam int SELW = `LORL_NUM_SLOTS * `LORL_SEL_W;

    // Decoding shared by the read and write paths
    function automatic logic inRelayWin(input logic [`LORL_ADDR_W-1:0] a);
        inRelayWin = a < `LORL_ADDR_CTRL;
    endfunction
    function automatic logic [1:0] relayOf(input logic [`LORL_ADDR_W-1:0] a);
        relayOf = a[5:4];
    endfunction

    // Bus handshake: request seen with wait high, answered next cycle
    lorl_bus_t busReg, busNext;
    logic waitReg, waitNext;
    logic [31:0] rdReg, rdNext;
    logic wrTake;

    // Register file
    logic [SELW-1:0] selReg [NR];
    logic [SELW-1:0] selNext [NR];
    logic [`LORL_CFG_W-1:0] cfgReg [NR];
    logic [`LORL_CFG_W-1:0] cfgNext [NR];
    lorl_time_t holdReg [NR];
    lorl_time_t holdNext [NR];
    lorl_time_t offReg [NR];
    lorl_time_t offNext [NR];
    logic remoteReg, remoteNext;
    logic [NR-1:0] scadaAckReg, scadaAckNext;
    logic groupAckReg, groupAckNext;

    // Timebase and health
    logic [15:0] tickCnt, tickCntNext;
    logic tickReg, tickNext;
    logic healthReg, healthNext;

    // Relay status collected from channels
    logic [NR-1:0] contactW, latchedW, stateW;

    always_comb begin
        busNext = busReg;
        waitNext = 1'b1;
        wrTake = 1'b0;
        case (busReg)
            LORL_IDLE: begin
                if (avs_read || avs_write) begin
                    busNext = LORL_ANSWER;
                    waitNext = 1'b0;
                end
            end
            LORL_ANSWER: begin
                // Master sees wait low at this edge; the write lands here
                wrTake = avs_write;
                busNext = LORL_IDLE;
            end
            default: busNext = LORL_IDLE;
        endcase
    end

    always_comb begin
        rdNext = rdReg;
        if (busReg == LORL_IDLE && avs_read) begin
            rdNext = 32'h00000000;
            if (inRelayWin(avs_address)) begin
                case (avs_address[3:2])
                    `LORL_OFS_SEL:
                        rdNext = {4'h0, selReg[relayOf(avs_address)]};
                    `LORL_OFS_CFG:
                        rdNext = {18'h00000, cfgReg[relayOf(avs_address)]};
                    `LORL_OFS_HOLD:
                        rdNext = {16'h0000, holdReg[relayOf(avs_address)]};
                    default:
                        rdNext = {16'h0000, offReg[relayOf(avs_address)]};
                endcase
            end else if (avs_address == `LORL_ADDR_CTRL) begin
                rdNext[`LORL_CTRL_REMOTE] = remoteReg;
            end else if (avs_address == `LORL_ADDR_STATUS) begin
                rdNext[3:0] = contactW;
                rdNext[7:4] = latchedW;
                rdNext[11:8] = stateW;
                rdNext[`LORL_STAT_HEALTH] = healthReg;
                rdNext[`LORL_STAT_REMOTE] = remoteReg;
            end
        end
    end

    always_comb begin
        for (int r = 0; r < NR; r++) begin
            selNext[r] = selReg[r];
            cfgNext[r] = cfgReg[r];
            holdNext[r] = holdReg[r];
            offNext[r] = offReg[r];
        end
        remoteNext = remoteReg;
        scadaAckNext = '0;
        groupAckNext = 1'b0;
        if (wrTake && inRelayWin(avs_address)) begin
            case (avs_address[3:2])
                `LORL_OFS_SEL:
                    selNext[relayOf(avs_address)] = avs_writedata[SELW-1:0];
                `LORL_OFS_CFG:
                    cfgNext[relayOf(avs_address)] =
                        avs_writedata[`LORL_CFG_W-1:0];
                `LORL_OFS_HOLD:
                    holdNext[relayOf(avs_address)] = avs_writedata[15:0];
                default:
                    offNext[relayOf(avs_address)] = avs_writedata[15:0];
            endcase
        end else if (wrTake && avs_address == `LORL_ADDR_CTRL) begin
            remoteNext = avs_writedata[`LORL_CTRL_REMOTE];
        end else if (wrTake && avs_address == `LORL_ADDR_ACK) begin
            scadaAckNext = avs_writedata[NR-1:0];
        end
        // Group ack, by pin or supervisory write, gated by remote enable
        groupAckNext = remoteReg && (group_output_ack_source
            || (wrTake && avs_address == `LORL_ADDR_ACK
            && avs_writedata[`LORL_ACK_GROUP]));
    end

    always_comb begin
        if (tickCnt == 16'(TICK_CYCLES - 1)) begin
            tickCntNext = 16'h0000;
            tickNext = 1'b1;
        end else begin
            tickCntNext = tickCnt + 16'h0001;
            tickNext = 1'b0;
        end
        // Boot not finished or a fault keeps the contact dropped
        healthNext = bootDone && !internalFault;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            busReg <= LORL_IDLE;
            waitReg <= 1'b1;
            rdReg <= 32'h00000000;
            remoteReg <= 1'b0;
            scadaAckReg <= '0;
            groupAckReg <= 1'b0;
            tickCnt <= 16'h0000;
            tickReg <= 1'b0;
            healthReg <= 1'b0;
        end else begin
            busReg <= busNext;
            waitReg <= waitNext;
            rdReg <= rdNext;
            remoteReg <= remoteNext;
            scadaAckReg <= scadaAckNext;
            groupAckReg <= groupAckNext;
            tickCnt <= tickCntNext;
            tickReg <= tickNext;
            healthReg <= healthNext;
        end
    end

    // Settings kept with the latches: wiping them on restart would unlatch
    always_ff @(posedge sys_clk or posedge retainRst) begin
        if (retainRst) begin
            for (int r = 0; r < NR; r++) begin
                selReg[r] <= `LORL_SEL_RST;
                cfgReg[r] <= `LORL_CFG_RST;
                holdReg[r] <= `LORL_TIME_RST;
                offReg[r] <= `LORL_TIME_RST;
            end
        end else begin
            for (int r = 0; r < NR; r++) begin
                selReg[r] <= selNext[r];
                cfgReg[r] <= cfgNext[r];
                holdReg[r] <= holdNext[r];
                offReg[r] <= offNext[r];
            end
        end
    end

    for (genvar g = 0; g < NR; g++) begin : gRelay
        lorl_relay_if rif();
        assign rif.sel = selReg[g];
        assign rif.inv = cfgReg[g][`LORL_CFG_INV_LSB +: `LORL_NUM_SLOTS];
        assign rif.collInv = cfgReg[g][`LORL_CFG_COLLINV];
        assign rif.closedCircuit = cfgReg[g][`LORL_CFG_CLOSED];
        assign rif.latchEn = cfgReg[g][`LORL_CFG_LATCH];
        assign rif.ackSel = cfgReg[g][`LORL_CFG_ACKSEL_LSB +: `LORL_SEL_W];
        assign rif.holdTicks = holdReg[g];
        assign rif.offTicks = offReg[g];
        assign rif.scadaAck = scadaAckReg[g];
        assign contactW[g] = rif.contact;
        assign latchedW[g] = rif.latched;
        assign stateW[g] = rif.logicState;

        lorl_relay_channel uChan (
            .sys_clk(sys_clk),
            .rst(rst),
            .retainRst(retainRst),
            .tick(tickReg),
            .trigIn(trigIn),
            .panelAck(panelAck[g]),
            .groupAck(groupAckReg),
            .ch(rif.chan)
        );
    end

    assign avs_readdata = rdReg;
    assign avs_waitrequest = waitReg;
    assign relayContact = contactW;
    assign health_contact = healthReg;
    assign healthLed = healthReg;

    a_group_gate: assert property (@(posedge sys_clk) disable iff (rst)
        groupAckReg |-> $past(remoteReg))
        else $error("group ack passed without remote enable");
    a_health_boot: assert property (@(posedge sys_clk) disable iff (rst)
        !bootDone |=> !health_contact)
        else $error("health contact up during boot");
    a_tick_period: assert property (@(posedge sys_clk) disable iff (rst)
        tickReg |=> !tickReg)
        else $error("timebase tick wider than one cycle");
    a_bus_answer: assert property (@(posedge sys_clk) disable iff (rst)
        (avs_read || avs_write) && waitReg && busReg == LORL_IDLE
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle after request");
endmodule // lorl_relay_top
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the latching output relay block
`timescale 1ns/1ns
`default_nettype none
`include "lorl_consts.svh"
module tb_top
    import lorl_pkg::*;
;
    localparam int unsigned TICK = 4;
    logic sys_clk, rst, retainRst;
    logic [`LORL_ADDR_W-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata, rdData;
    lorl_trig_t trigIn;
    logic [`LORL_NUM_RELAYS-1:0] panelAck, relayContact;
    logic group_output_ack_source, bootDone, internalFault;
    logic health_contact, healthLed;
    int n_mismatch, cmp_count;

    lorl_relay_top #(.TICK_CYCLES(TICK)) DUT (.sys_clk(sys_clk), .rst(rst),
        .retainRst(retainRst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .trigIn(trigIn),
        .panelAck(panelAck),
        .group_output_ack_source(group_output_ack_source),
        .bootDone(bootDone), .internalFault(internalFault),
        .relayContact(relayContact), .health_contact(health_contact),
        .healthLed(healthLed));

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic print_verdict();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [6:0] ra(input int r, input int ofs);
        return 7'(r * `LORL_RELAY_STRIDE + ofs * 4);
    endfunction

    // Holds the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [6:0] a,
        input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        for (i = 0; i < 50; i++) begin
            @(posedge sys_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 50) begin
            n_mismatch++;
            print_verdict();
        end
        rdData = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic trig(input int i, input logic v);
        @(posedge sys_clk);
        trigIn[i] <= v;
    endtask

    task automatic t_reset_map();
        chk(relayContact, 4'h0);
        chk(health_contact, 1'b0);
        bus(1'b0, ra(0, `LORL_OFS_SEL), 0);
        chk(rdData, `LORL_SEL_RST);
        bus(1'b1, 7'h4c, 32'hffffffff);
        bus(1'b0, 7'h4c, 0);
        chk(rdData, 32'h0);
        bus(1'b0, `LORL_ADDR_ACK, 0);
        chk(rdData, 32'h0);
    endtask

    task automatic t_combine();
        bus(1'b1, ra(0, `LORL_OFS_SEL), 32'h07000001);
        settle(4);
        chk(relayContact[0], 1'b0);
        trig(6, 1'b1);
        settle(4);
        chk(relayContact[0], 1'b1);
        trig(6, 1'b0);
        bus(1'b1, ra(0, `LORL_OFS_CFG), 32'h2);
        settle(4);
        chk(relayContact[0], 1'b0);
        bus(1'b1, ra(0, `LORL_OFS_CFG), 32'h1);
        settle(4);
        chk(relayContact[0], 1'b1);
        bus(1'b1, ra(0, `LORL_OFS_CFG), 32'h80);
        settle(4);
        chk(relayContact[0], 1'b1);
        bus(1'b0, ra(0, `LORL_OFS_CFG), 0);
        chk(rdData, 32'h80);
        bus(1'b1, ra(1, `LORL_OFS_CFG), 32'hff);
        settle(4);
        chk(relayContact[1], 1'b0);
    endtask

    task automatic t_closed();
        bus(1'b1, ra(1, `LORL_OFS_SEL), 32'h1);
        bus(1'b1, ra(1, `LORL_OFS_CFG), 32'h100);
        settle(4);
        chk(relayContact[1], 1'b1);
        trig(0, 1'b1);
        settle(4);
        chk(relayContact[1], 1'b0);
        chk(relayContact[0], 1'b0);
        trig(0, 1'b0);
    endtask

    // Sets the latch of relay 2 by a pulse on trigger 1, then waits gap cycles and checks the contact is held
    task automatic latch2(input int gap);
        trig(1, 1'b1);
        trig(1, 1'b0);
        settle(gap);
        chk(relayContact[2], 1'b1);
    endtask

    task automatic t_latch();
        bus(1'b1, ra(2, `LORL_OFS_SEL), 32'h2);
        bus(1'b1, ra(2, `LORL_OFS_OFFDLY), 32'h2);
        bus(1'b1, ra(2, `LORL_OFS_CFG), 32'he00);
        latch2(1);
        trig(2, 1'b1);
        trig(2, 1'b0);
        settle(4);
        chk(relayContact[2], 1'b1);
        settle(20);
        trig(2, 1'b1);
        trig(2, 1'b0);
        settle(4);
        chk(relayContact[2], 1'b0);
        trig(1, 1'b1);
        @(posedge sys_clk);
        panelAck <= 4'h4;
        @(posedge sys_clk);
        panelAck <= 4'h0;
        trig(1, 1'b0);
        settle(4);
        chk(relayContact[2], 1'b1);
        settle(20);
        @(posedge sys_clk);
        panelAck <= 4'h4;
        @(posedge sys_clk);
        panelAck <= 4'h0;
        settle(4);
        chk(relayContact[2], 1'b0);
    endtask

    task automatic t_group();
        latch2(24);
        @(posedge sys_clk);
        group_output_ack_source <= 1'b1;
        @(posedge sys_clk);
        group_output_ack_source <= 1'b0;
        bus(1'b1, `LORL_ADDR_ACK, 32'h100);
        settle(4);
        chk(relayContact[2], 1'b1);
        bus(1'b1, `LORL_ADDR_CTRL, 32'h1);
        @(posedge sys_clk);
        group_output_ack_source <= 1'b1;
        @(posedge sys_clk);
        group_output_ack_source <= 1'b0;
        settle(4);
        chk(relayContact[2], 1'b0);
        latch2(24);
        bus(1'b1, `LORL_ADDR_ACK, 32'h4);
        settle(4);
        chk(relayContact[2], 1'b0);
        latch2(24);
        bus(1'b0, `LORL_ADDR_STATUS, 0);
        chk(rdData[6], 1'b1);
        chk(rdData[17], 1'b1);
        // Restart alone must bring the latched contact back
        @(posedge sys_clk);
        rst <= 1'b1;
        settle(3);
        chk({avs_waitrequest, relayContact[2]}, 2'b10);
        chk(avs_readdata, 32'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
        settle(3);
        chk(relayContact[2], 1'b1);
        bus(1'b1, ra(2, `LORL_OFS_CFG), 32'h0);
        settle(4);
        chk(relayContact[2], 1'b0);
        bus(1'b1, ra(2, `LORL_OFS_CFG), 32'he00);
        latch2(4);
        bus(1'b1, ra(2, `LORL_OFS_SEL), 32'h0);
        settle(4);
        chk(relayContact[2], 1'b0);
    endtask

    task automatic t_dwell();
        int i;
        bus(1'b1, ra(3, `LORL_OFS_HOLD), 32'h3);
        bus(1'b1, ra(3, `LORL_OFS_SEL), 32'h1);
        trig(0, 1'b1);
        trig(0, 1'b0);
        settle(3);
        chk(relayContact[3], 1'b1);
        // Three ticks, less one for tick phase, is the shortest dwell
        settle(2 * TICK - 3);
        chk(relayContact[3], 1'b1);
        for (i = 0; i < 40 && relayContact[3] !== 1'b0; i++) settle(1);
        chk(relayContact[3], 1'b0);
    endtask

    task automatic t_health();
        chk(health_contact, 1'b0);
        @(posedge sys_clk);
        bootDone <= 1'b1;
        settle(3);
        chk({health_contact, healthLed}, 2'b11);
        @(posedge sys_clk);
        internalFault <= 1'b1;
        settle(3);
        chk(health_contact, 1'b0);
    endtask

    initial begin
        #4000000;
        n_mismatch++;
        print_verdict();
    end

    initial begin
        n_mismatch = 0;
        cmp_count = 0;
        rst = 1'b1;
        retainRst = 1'b1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        trigIn = '0;
        panelAck = '0;
        group_output_ack_source = 1'b0;
        bootDone = 1'b0;
        internalFault = 1'b0;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        retainRst <= 1'b0;
        settle(1);
        t_reset_map();
        t_combine();
        t_closed();
        t_latch();
        t_group();
        t_dwell();
        t_health();
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
